// ==== design/dsb_pkg.sv ====
/*
 * dsb_pkg: constants for the slave diagnostic response builder.
 * assumes a single clock domain; all offsets are byte positions in the response.
 */
package dsb_pkg;
    // ------------------------------------------------------------
    // response layout
    // ------------------------------------------------------------
    localparam int DSB_NAREA = 4;                  // configured transfer-memory areas
    localparam int DSB_POS_STAT1 = 0;              // first status byte
    localparam int DSB_POS_STAT2 = 1;              // second status byte
    localparam int DSB_POS_STAT3 = 2;              // third status byte
    localparam int DSB_POS_MADDR = 3;              // owning master address
    localparam int DSB_POS_ID_HI = 4;              // identification, sent first
    localparam int DSB_POS_ID_LO = 5;              // identification, sent second
    localparam int DSB_POS_MOD = 6;                // module diagnostics header
    localparam int DSB_MOD_LEN = 2;                // header plus one bitmap byte
    localparam int DSB_POS_STN = DSB_POS_MOD + DSB_MOD_LEN;
    localparam int DSB_STN_HDR = 4;                // station entry header bytes
    localparam int DSB_DIAG_LEN = 16;              // diagnostic interrupt payload
    localparam int DSB_DIAG_USED = 4;              // payload bytes with content
    localparam int DSB_PROC_LEN = 4;               // process interrupt payload
    localparam int DSB_STN_MAX = 20;               // largest station entry
    // ------------------------------------------------------------
    // field values
    // ------------------------------------------------------------
    localparam logic [7:0] DSB_NO_MASTER = 8'hFF;  // unconfigured slave
    localparam logic [7:0] DSB_TYPE_DIAG = 8'h01;  // diagnostic interrupt code
    localparam logic [7:0] DSB_TYPE_PROC = 8'h02;  // process interrupt code
    localparam logic [7:0] DSB_AREA_OFS = 8'h03;   // area number offset
    localparam logic [7:0] DSB_MOD_HDR = 8'h42;    // module header: code 01, len 2
    localparam logic [7:0] DSB_ID_HI = 8'h5A;      // arbitrary identification value
    localparam logic [7:0] DSB_ID_LO = 8'hA5;      // arbitrary identification value
    localparam int DSB_S1_NOADDR = 0;
    localparam int DSB_S1_NOTRDY = 1;
    localparam int DSB_S1_CFGERR = 2;
    localparam int DSB_S1_RUNSTOP = 3;
    localparam int DSB_S1_UNSUP = 4;
    localparam int DSB_S1_TYPERR = 6;
    localparam int DSB_S1_OTHER = 7;
    localparam int DSB_S2_PRMREQ = 0;
    localparam int DSB_S2_STATIC = 1;
    localparam int DSB_S2_PRESENT = 2;
    localparam int DSB_S2_WDOG = 3;
    localparam int DSB_S2_DEACT = 7;
    localparam int DSB_S3_OVF = 7;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DSB_RST_BYTE = 8'h00;
    localparam logic [5:0] DSB_RST_IDX = 6'h00;
    typedef enum {DSB_IDLE, DSB_SEND} dsb_state_e;
endpackage

// ==== design/dsb_sticky.sv ====
/*
 * dsb_sticky: one sticky event flag, set wins over clear.
 * assumes set and clear are synchronous single-cycle strobes.
 */
module dsb_sticky (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic set,
    input wire logic clr,
    // state
    output logic flag
);
    import dsb_pkg::*;
    typedef struct packed {logic flag;} dsb_sticky_s;
    dsb_sticky_s st_reg;
    dsb_sticky_s st_next;
    // ------------------------------------------------------------
    // next state: a set in the clear cycle survives
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (clr) begin
            st_next.flag = 1'b0;
        end
        if (set) begin
            st_next.flag = 1'b1;
        end
    end
    // register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign flag = st_reg.flag;
endmodule // dsb_sticky

// ==== design/dsb_builder.sv ====
/*
 * dsb_builder: serialises the slave diagnostic response byte by byte.
 * assumes the link layer asks with a one-cycle request and takes each byte
 * while out_valid and out_ready are high; status inputs are synchronous.
 */
module dsb_builder (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // station condition inputs
    input wire logic no_addr,
    input wire logic not_ready,
    input wire logic cfg_fault,
    input wire logic run_to_stop,
    input wire logic unsupported,
    input wire logic type_fault,
    input wire logic other_master,
    input wire logic prm_request,
    input wire logic static_diag,
    input wire logic wdog_on,
    input wire logic deactivated,
    input wire logic configured,
    input wire logic [7:0] master_addr,
    // interrupt event input
    input wire logic ev_valid,
    input wire logic ev_proc,
    input wire logic [1:0] ev_area,
    input wire logic [31:0] ev_data,
    // response port
    input wire logic req,
    output logic busy,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_last
);
    import dsb_pkg::*;
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dsb_state_e st;
        logic [5:0] idx;        // byte index in response
        logic [5:0] len;        // total response length
        logic [7:0] data;       // previous cycle's port byte; not driven out
        logic valid;
        logic pend;             // entry held for the current response
        logic pend_proc;        // held entry is a process interrupt
        logic [1:0] pend_area;
        logic [31:0] pend_data;
        logic [7:0] snap1;      // status snapshot taken at request
        logic [7:0] snap2;
        logic [7:0] snap3;
        logic [7:0] snap_ma;
    } dsb_s;
    dsb_s s_reg;
    dsb_s s_next;
    logic ovf_flag;             // sticky overflow
    logic ovf_set;
    logic ovf_clr;
    logic [5:0] stn_len;
    logic [7:0] byte_sel;
    logic [5:0] rel;
    logic take;
    // ------------------------------------------------------------
    // overflow flag: new event while one is still unread
    // ------------------------------------------------------------
    assign take = s_reg.valid && out_ready;
    assign ovf_set = ev_valid && s_reg.pend;
    assign ovf_clr = take && s_reg.idx == 6'(DSB_POS_STAT3);
    dsb_sticky u_ovf (
        .clk(clk),
        .nrst(nrst),
        .set(ovf_set),
        .clr(ovf_clr),
        .flag(ovf_flag)
    );
    // ------------------------------------------------------------
    // station entry length follows its kind
    // ------------------------------------------------------------
    always_comb begin
        if (s_reg.pend_proc) begin
            stn_len = 6'(DSB_STN_HDR + DSB_PROC_LEN);
        end else begin
            stn_len = 6'(DSB_STN_HDR + DSB_DIAG_LEN);
        end
    end
    // ------------------------------------------------------------
    // byte mux: field order is fixed
    // ------------------------------------------------------------
    always_comb begin
        rel = s_reg.idx - 6'(DSB_POS_STN);
        byte_sel = DSB_RST_BYTE;
        case (s_reg.idx)
            6'(DSB_POS_STAT1): byte_sel = s_reg.snap1;
            6'(DSB_POS_STAT2): byte_sel = s_reg.snap2;
            6'(DSB_POS_STAT3): byte_sel = s_reg.snap3;
            6'(DSB_POS_MADDR): byte_sel = s_reg.snap_ma;
            6'(DSB_POS_ID_HI): byte_sel = DSB_ID_HI;
            6'(DSB_POS_ID_LO): byte_sel = DSB_ID_LO;
            6'(DSB_POS_MOD): byte_sel = DSB_MOD_HDR;
            6'(DSB_POS_MOD + 1): begin
                // one bit per area, bit n for area n
                byte_sel = DSB_RST_BYTE;
                if (s_reg.pend) begin
                    byte_sel[s_reg.pend_area] = 1'b1;
                end
            end
            default: begin
                case (rel)
                    6'd0: byte_sel = {2'b00, stn_len};
                    6'd1: byte_sel = s_reg.pend_proc ? DSB_TYPE_PROC : DSB_TYPE_DIAG;
                    6'd2: byte_sel = {6'b0, s_reg.pend_area} + 8'h01 + DSB_AREA_OFS;
                    6'd3: byte_sel = DSB_RST_BYTE;
                    6'd4: byte_sel = s_reg.pend_data[31:24];
                    6'd5: byte_sel = s_reg.pend_data[23:16];
                    6'd6: byte_sel = s_reg.pend_data[15:8];
                    6'd7: byte_sel = s_reg.pend_data[7:0];
                    default: byte_sel = DSB_RST_BYTE;
                endcase
            end
        endcase
    end
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // latest event replaces an unread one; master keeps history
        if (ev_valid) begin
            s_next.pend = 1'b1;
            s_next.pend_proc = ev_proc;
            s_next.pend_area = ev_area;
            s_next.pend_data = ev_data;
        end
        case (s_reg.st)
            DSB_IDLE: begin
                if (req) begin
                    s_next.st = DSB_SEND;
                    s_next.idx = DSB_RST_IDX;
                    s_next.snap1 = DSB_RST_BYTE;
                    s_next.snap1[DSB_S1_NOADDR] = no_addr;
                    s_next.snap1[DSB_S1_NOTRDY] = not_ready;
                    s_next.snap1[DSB_S1_CFGERR] = cfg_fault;
                    s_next.snap1[DSB_S1_RUNSTOP] = run_to_stop;
                    s_next.snap1[DSB_S1_UNSUP] = unsupported;
                    s_next.snap1[DSB_S1_TYPERR] = type_fault;
                    s_next.snap1[DSB_S1_OTHER] = other_master;
                    s_next.snap2 = DSB_RST_BYTE;
                    s_next.snap2[DSB_S2_PRMREQ] = prm_request;
                    s_next.snap2[DSB_S2_STATIC] = static_diag;
                    s_next.snap2[DSB_S2_PRESENT] = 1'b1;
                    s_next.snap2[DSB_S2_WDOG] = wdog_on;
                    s_next.snap2[DSB_S2_DEACT] = deactivated;
                    s_next.snap3 = {ovf_flag, 7'b0};
                    s_next.snap_ma = configured ? master_addr : DSB_NO_MASTER;
                    // entry is included only if one is held
                    s_next.len = s_reg.pend ? 6'(DSB_POS_STN) + stn_len : 6'(DSB_POS_STN);
                    s_next.valid = 1'b1;
                end
            end
            DSB_SEND: begin
                s_next.data = byte_sel;
                if (take) begin
                    s_next.idx = s_reg.idx + 6'd1;
                    if (s_reg.idx == s_reg.len - 6'd1) begin
                        s_next.st = DSB_IDLE;
                        s_next.valid = 1'b0;
                        // entry handed over; a newer event stays held
                        if (!ev_valid) begin
                            s_next.pend = 1'b0;
                        end
                    end
                end
            end
            default: s_next.st = DSB_IDLE;
        endcase
    end
    // register the whole state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    // ------------------------------------------------------------
    // outputs: data is the mux of registered state; bitmap and entry bytes follow a new event even while valid
    // ------------------------------------------------------------
    assign busy = s_reg.st == DSB_SEND;
    assign out_valid = s_reg.valid;
    assign out_data = byte_sel;
    assign out_last = s_reg.valid && s_reg.idx == s_reg.len - 6'd1;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_req_idle;
        req && s_reg.st == DSB_IDLE;
    endsequence
    a_present_bit: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx == 6'(DSB_POS_STAT2) |-> out_data[2] && out_data[6:4] == 3'b0)
        else $error("second status byte has wrong fixed bits");
    a_master_none: assert property (@(posedge clk) disable iff (!nrst)
        s_req_idle and !configured |=> s_reg.snap_ma == DSB_NO_MASTER)
        else $error("unconfigured master byte not all ones");
    a_stat1_noaddr: assert property (@(posedge clk) disable iff (!nrst)
        s_req_idle ##1 (out_valid && s_reg.idx == 6'd0) |-> out_data[0] == $past(no_addr))
        else $error("first status bit zero wrong");
    a_stat1_zero: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx == 6'd0 |-> !out_data[5])
        else $error("first status bit five not zero");
    a_stat3_zero: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx == 6'(DSB_POS_STAT3) |-> out_data[6:0] == 7'b0)
        else $error("third status low bits not zero");
    a_ovf_sticky: assert property (@(posedge clk) disable iff (!nrst)
        ovf_set |=> ovf_flag)
        else $error("overflow event lost");
    a_id_order: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx == 6'(DSB_POS_ID_HI) && take |=>
        out_data == DSB_ID_LO && s_reg.idx == 6'(DSB_POS_ID_LO))
        else $error("identification bytes out of order");
    a_entry_len: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx == 6'(DSB_POS_STN) |->
        out_data[7:6] == 2'b0 && out_data[5:0] <= 6'(DSB_STN_MAX))
        else $error("station entry header bad");
    a_entry_type: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx == 6'(DSB_POS_STN + 1) |->
        out_data == (s_reg.pend_proc ? DSB_TYPE_PROC : DSB_TYPE_DIAG))
        else $error("station entry type code wrong");
    a_entry_area: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx == 6'(DSB_POS_STN + 2) |-> out_data >= 8'h04)
        else $error("area number not offset by three");
    a_diag_tail: assert property (@(posedge clk) disable iff (!nrst)
        out_valid && s_reg.idx >= 6'(DSB_POS_STN + 8) |-> out_data == 8'h00)
        else $error("diagnostic tail not zero");
endmodule // dsb_builder

// ==== testbench/dsb_master_model.sv ====
/*
 * dsb_master_model: behavioural polling master for the diagnostic builder.
 * assumes it alone drives req and out_ready, changing them just after rising edges.
 */
module dsb_master_model (
    // clock
    input wire logic clk,
    // response port
    output logic req,
    output logic out_ready,
    input wire logic busy,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // receive store
    // ------------------------------------------------------------
    logic [7:0] rx [0:63]; // whole response kept before the next poll
    int rx_n; // bytes taken in the last poll
    // listener copy of every accepted byte, as a direct-exchange receiver sees it
    logic [7:0] snp [0:63];
    int snp_n = 0; // running count; index wraps as a ring
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            snp[6'(snp_n)] <= out_data;
            snp_n <= snp_n + 1;
        end
    end
    initial begin
        req = 1'b0;
        out_ready = 1'b0;
        rx_n = 0;
    end
    // ------------------------------------------------------------
    // one poll: request, then take bytes until the final one
    // ------------------------------------------------------------
    // slow stalls every other cycle; dup asks again while busy, which must be ignored
    task automatic poll(input bit slow, input bit dup);
        int k;
        bit fin;
        fin = 1'b0;
        rx_n = 0;
        req <= 1'b1;
        out_ready <= 1'b0;
        for (k = 0; k < 200 && !fin; k++) begin
            @(posedge clk);
            // sampled before the edge's updates land, like the design sees them
            if (out_valid && out_ready) begin
                rx[rx_n] = out_data;
                rx_n++;
                fin = out_last;
            end
            req <= dup && (k == 3);
            out_ready <= fin ? 1'b0 : (slow ? k[0] : 1'b1);
        end
        // let busy fall before anyone asks again
        @(posedge clk);
        @(posedge clk);
    endtask
endmodule // dsb_master_model

// ==== testbench/dp_slave_diag_builder_tb.sv ====
/*
 * dp_slave_diag_builder_tb: self-checking bench for dsb_builder.
 * assumes dsb_master_model polls the response; conditions change at rising edges.
 */
module dp_slave_diag_builder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsb_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [10:0] cond = '0; // station conditions, byte 0 bits then byte 1 bits
    logic configured = 1'b0;
    logic [7:0] master_addr = 8'h00;
    logic ev_valid = 1'b0;
    logic ev_proc = 1'b0;
    logic [1:0] ev_area = 2'h0;
    logic [31:0] ev_data = 32'h0;
    logic req, busy, out_valid, out_ready, out_last;
    logic [7:0] out_data;
    logic [7:0] eq[$]; // expected response
    int n_fail = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    // ------------------------------------------------------------
    // design and polling master
    // ------------------------------------------------------------
    dsb_builder dut (.clk(clk), .nrst(nrst), .no_addr(cond[0]), .not_ready(cond[1]),
        .cfg_fault(cond[2]), .run_to_stop(cond[3]), .unsupported(cond[4]),
        .type_fault(cond[5]), .other_master(cond[6]), .prm_request(cond[7]),
        .static_diag(cond[8]), .wdog_on(cond[9]), .deactivated(cond[10]),
        .configured(configured), .master_addr(master_addr), .ev_valid(ev_valid),
        .ev_proc(ev_proc), .ev_area(ev_area), .ev_data(ev_data), .req(req), .busy(busy),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_last(out_last));
    dsb_master_model pm (.clk(clk), .req(req), .out_ready(out_ready), .busy(busy),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last));
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // header part of every response; identification bytes are the package's arbitrary pair
    task automatic base(input logic [7:0] s1, s2, s3, ma, bm);
        eq = {s1, s2, s3, ma, DSB_ID_HI, DSB_ID_LO, DSB_MOD_HDR, bm};
    endtask
    // length first, then every byte in order
    task automatic cmp_resp();
        chk(8'(pm.rx_n), 8'(eq.size()));
        foreach (eq[i]) chk(pm.rx[i], eq[i]);
        // port must be back to idle once the poll has finished
        chk({5'b0, busy, out_valid, out_last}, 8'h00);
        // the listener must have seen the same final byte as the master
        chk(pm.snp[6'(pm.snp_n - 1)], eq[eq.size() - 1]);
    endtask
    // one event pulse; last low keeps ev_valid up for a back-to-back event
    task automatic ev(input logic proc, input logic [1:0] area, input logic [31:0] d,
                      input bit last);
        ev_valid <= 1'b1;
        ev_proc <= proc;
        ev_area <= area;
        ev_data <= d;
        @(posedge clk);
        if (last) ev_valid <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // unconfigured slave with no conditions: only fixed content
    task automatic t_idle();
        pm.poll(0, 0);
        base(8'h00, 8'h04, 8'h00, 8'hFF, 8'h00);
        cmp_resp();
    endtask
    // each condition alone, then all together, on a configured slave
    task automatic t_status();
        int p1[7] = '{0, 1, 2, 3, 4, 6, 7};
        int p2[4] = '{0, 1, 3, 7};
        logic [10:0] v;
        logic [7:0] e1, e2;
        for (int i = 0; i < 12; i++) begin
            v = (i == 11) ? 11'h7FF : 11'(1 << i);
            cond <= v;
            configured <= 1'b1;
            master_addr <= 8'h1C;
            e1 = 8'h00;
            e2 = 8'h04;
            for (int j = 0; j < 7; j++) if (v[j]) e1[p1[j]] = 1'b1;
            for (int j = 0; j < 4; j++) if (v[7 + j]) e2[p2[j]] = 1'b1;
            @(posedge clk);
            pm.poll(0, 0);
            base(e1, e2, 8'h00, 8'h1C, 8'h00);
            cmp_resp();
        end
        cond <= '0;
    endtask
    // diagnostic interrupt in the last area, master stalling; consumed afterwards
    task automatic t_diag();
        ev(1'b0, 2'h3, 32'hC13E7B90, 1);
        pm.poll(1, 0);
        base(8'h00, 8'h04, 8'h00, 8'h1C, 8'h08);
        eq = {eq, 8'h14, 8'h01, 8'h07, 8'h00, 8'hC1, 8'h3E, 8'h7B, 8'h90};
        repeat (12) eq.push_back(8'h00);
        cmp_resp();
        pm.poll(0, 0);
        base(8'h00, 8'h04, 8'h00, 8'h1C, 8'h00);
        cmp_resp();
    endtask
    // two process interrupts back to back: latest kept, overflow shown once
    task automatic t_proc_ovf();
        ev(1'b1, 2'h0, 32'h11223344, 0);
        ev(1'b1, 2'h2, 32'hF00DBEEF, 1);
        pm.poll(0, 1);
        base(8'h00, 8'h04, 8'h80, 8'h1C, 8'h04);
        eq = {eq, 8'h08, 8'h02, 8'h06, 8'h00, 8'hF0, 8'h0D, 8'hBE, 8'hEF};
        cmp_resp();
        pm.poll(0, 0);
        base(8'h00, 8'h04, 8'h00, 8'h1C, 8'h00);
        cmp_resp();
    endtask
    // ------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_idle();
        t_status();
        t_diag();
        t_proc_ovf();
        conclude();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #(8 * 20000);
        n_fail++;
        conclude();
    end
endmodule // dp_slave_diag_builder_tb
